/* File: bench/core_model.sv */
// Core stand-in that finishes context save and restore
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Answer delay, slow or prompt
  input  wire logic [2:0] lat,
  // Stack jobs and their answers
  input  wire logic       push_context,
  input  wire logic       pop_context,
  output var  logic       save_done,
  output var  logic       restore_done
);
  logic [2:0] cnt_reg; // Cycles spent on the job
  // One-cycle answer lat+1 cycles into the job; idle drops the count
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg      <= 3'h0;
      save_done    <= 1'h0;
      restore_done <= 1'h0;
    end else if (!(push_context || pop_context) || save_done || restore_done) begin
      cnt_reg      <= 3'h0;
      save_done    <= 1'h0;
      restore_done <= 1'h0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      if (cnt_reg == lat) begin
        save_done    <= push_context;
        restore_done <= pop_context;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/vectored_interrupt_controller_tb.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller_tb;
  logic        clock = 1'h0;
  logic        rst_n = 1'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [3:0]  ext = 4'hF; // Lines idle high
  logic [3:0]  nand_block_n = 4'hF;
  logic [13:0] periph_flag = 14'h0000;
  logic [13:0] periph_clear = 14'h0000;
  logic        supply = 1'h0;
  logic        boundary = 1'h0;
  logic        trap = 1'h0;
  logic        ret = 1'h0;
  logic [3:0]  modes = 4'h0; // Wait, halt, active halt, wake halt
  logic [2:0]  lat = 3'h0;
  wire  [7:0]  reg_rdata;
  wire  [15:0] vector_addr;
  wire         irq_take, push_context, pop_context, load_pc, global_mask;
  wire         wake_core, save_done, restore_done;
  int          err_count = 0;
  int          tests_run = 0;
  logic [7:0]  d;
  logic [15:0] vecs [5] = '{16'hFFFA, 16'hFFF0, 16'hFFEC, 16'hFFEA, 16'hFFE0};
  vectored_interrupt_controller DUT (.clock(clock), .clk_en(1'h1), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_line_zero(ext[0]), .external_line_one(ext[1]),
    .external_line_two(ext[2]), .external_line_three(ext[3]),
    .nand_block_n(nand_block_n), .periph_flag(periph_flag),
    .periph_clear(periph_clear), .supply_detect_flag(supply),
    .instr_boundary(boundary), .trap_exec(trap), .return_from_interrupt(ret),
    .save_done(save_done), .restore_done(restore_done), .wait_mode(modes[0]),
    .halt_mode(modes[1]), .active_halt_mode(modes[2]), .awu_halt_mode(modes[3]),
    .irq_take(irq_take), .push_context(push_context), .pop_context(pop_context),
    .load_pc(load_pc), .vector_addr(vector_addr), .global_mask(global_mask),
    .wake_core(wake_core));
  core_model CORE (.clock(clock), .rst_n(rst_n), .lat(lat), .push_context(push_context),
    .pop_context(pop_context), .save_done(save_done), .restore_done(restore_done));
  always #2 clock = ~clock;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'h0;
    @(negedge clock);
    v = reg_rdata;
  endtask
  task automatic pulse(input logic [13:0] f, input logic clr);
    @(posedge clock);
    if (clr) periph_clear <= f;
    else periph_flag <= f;
    @(posedge clock);
    periph_clear <= 14'h0000;
    periph_flag <= 14'h0000;
  endtask
  task automatic line(input logic v);
    @(posedge clock);
    ext[0] <= v;
    cyc(3);
  endtask
  // Boundary, wait for the vector, then return
  task automatic serve(input logic t, input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge clock);
    boundary <= 1'h1;
    trap <= t;
    @(posedge clock);
    boundary <= 1'h0;
    trap <= 1'h0;
    while (load_pc !== 1'h1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk(load_pc, 1'h1);
    chk(vector_addr, exp);
    chk(global_mask, 1'h1);
    @(posedge clock);
    ret <= 1'h1;
    @(posedge clock);
    ret <= 1'h0;
    n = 0;
    while (global_mask !== 1'h0 && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk(global_mask, 1'h0);
  endtask
  task automatic t_reset;
    chk(global_mask, 1'h1);
    for (int a = 0; a < 6; a++) begin
      rd((a == 5) ? 4'hF : a[3:0], d);
      chk(d, 8'h00);
    end
    rd(4'h5, d);
    chk(d, 8'h10);
  endtask
  // Masked pending, wake by mode, clearing sequence
  task automatic t_wake;
    wr(4'h1, 8'h20);
    pulse(14'h0060, 1'h0);
    for (int m = 1; m < 4; m++) begin
      @(posedge clock);
      modes <= 4'h1 << m;
      cyc(2);
      chk(wake_core, 1'h0);
    end
    @(posedge clock);
    modes <= 4'h1;
    cyc(2);
    chk(wake_core, 1'h1);
    rd(4'h3, d);
    chk(d, 8'h60);
    pulse(14'h0020, 1'h1);
    cyc(2);
    chk(wake_core, 1'h0);
    pulse(14'h0040, 1'h1);
    rd(4'h3, d);
    chk(d, 8'h00);
    @(posedge clock);
    modes <= 4'h0;
  endtask
  // Edge codes, latch clear on entry, blocked source
  task automatic t_ext;
    for (int c = 1; c < 4; c++) begin
      wr(4'h5, 8'h01);
      wr(4'h0, c[7:0]);
      line(1'h0);
      rd(4'h3, d);
      chk(d[1], c != 1);
      line(1'h1);
      rd(4'h3, d);
      chk(d[1], 1'h1);
      wr(4'h5, 8'h00);
      wr(4'h0, 8'h02);
      serve(1'h0, 16'hFFF8);
      rd(4'h3, d);
      chk(d[1], 1'h0);
    end
    rd(4'h0, d);
    chk(d, 8'h03);
    @(posedge clock);
    nand_block_n <= 4'hE;
    line(1'h0);
    line(1'h1);
    rd(4'h3, d);
    chk(d[1], 1'h0);
  endtask
  task automatic t_prio;
    @(posedge clock);
    lat <= 3'h3;
    wr(4'h1, 8'h21);
    wr(4'h2, 8'hA1);
    supply <= 1'h1;
    pulse(14'h2121, 1'h0);
    supply <= 1'h0;
    rd(4'h2, d);
    chk(d, 8'hA1);
    rd(4'h4, d);
    chk(d, 8'h21);
    rd(4'h5, d);
    chk(d, 8'h00);
    @(posedge clock);
    modes <= 4'h2;
    cyc(2);
    chk(wake_core, 1'h0);
    @(posedge clock);
    modes <= 4'hA;
    cyc(2);
    chk(wake_core, 1'h1);
    @(posedge clock);
    modes <= 4'h0;
    for (int i = 0; i < 5; i++) serve(1'h0, vecs[i]);
  endtask
  task automatic t_trap;
    wr(4'h5, 8'h01);
    pulse(14'h0001, 1'h0);
    serve(1'h1, 16'hFFFC);
    serve(1'h1, 16'hFFFC);
    serve(1'h0, 16'hFFFA);
    rd(4'h7, d);
    chk(d, 8'hFF);
    rd(4'h6, d);
    chk(d, 8'hFA);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'h1;
    cyc(3);
    t_reset;
    t_wake;
    t_ext;
    t_prio;
    t_trap;
    test_done;
  end
  // Hang guard, well past the expected run
  initial begin
    #200000;
    err_count++;
    test_done;
  end
endmodule
`default_nettype wire

/* File: bench/vic_checker.sv */
// Assertions on the core handshake of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defines.vh"
module vic_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Core side
  input wire logic        instr_boundary,
  input wire logic        trap_exec,
  input wire logic        save_done,
  input wire logic        restore_done,
  input wire logic        irq_take,
  input wire logic        push_context,
  input wire logic        pop_context,
  input wire logic        load_pc,
  input wire logic [15:0] vector_addr,
  input wire logic        global_mask
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Steps of entry and return
  sequence s_saved; push_context && save_done; endsequence
  sequence s_restored; pop_context && restore_done; endsequence
  sequence s_trap; instr_boundary && trap_exec ##1 irq_take; endsequence
  property p_push; irq_take |-> push_context; endproperty
  a_push:
    assert property (p_push) else $error("entry without save");
  property p_mask; irq_take |=> global_mask; endproperty
  a_mask:
    assert property (p_mask) else $error("mask not set on entry");
  property p_bound; irq_take |-> $past(instr_boundary); endproperty
  a_bound:
    assert property (p_bound) else $error("entry off boundary");
  property p_gate; irq_take |-> $past(trap_exec) || !$past(global_mask); endproperty
  a_gate:
    assert property (p_gate) else $error("entry while masked");
  property p_load; s_saved |=> load_pc; endproperty
  a_load:
    assert property (p_load) else $error("no vector after save");
  property p_vec; load_pc |-> !vector_addr[0] && vector_addr >= 16'hFFE0
    && vector_addr <= `VEC_TRAP; endproperty
  a_vec:
    assert property (p_vec) else $error("vector out of table");
  property p_trap; s_trap |-> ##[1:40] (load_pc && vector_addr == `VEC_TRAP); endproperty
  a_trap:
    assert property (p_trap) else $error("trap vector missing");
  property p_ret; s_restored |=> !global_mask; endproperty
  a_ret:
    assert property (p_ret) else $error("mask kept after return");
endmodule
bind vectored_interrupt_controller vic_checker chk_i (.clock(clock), .rst_n(rst_n),
  .instr_boundary(instr_boundary), .trap_exec(trap_exec), .save_done(save_done),
  .restore_done(restore_done), .irq_take(irq_take), .push_context(push_context),
  .pop_context(pop_context), .load_pc(load_pc), .vector_addr(vector_addr),
  .global_mask(global_mask));
`default_nettype wire

/* File: verilog/irq_ctrl_defines.vh */
// Constants for the vectored interrupt controller
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH

// Register offsets on the plain register port
`define OFS_SENSE      4'h0
`define OFS_ENABLE_LO  4'h1
`define OFS_ENABLE_HI  4'h2
`define OFS_PEND_LO    4'h3
`define OFS_PEND_HI    4'h4
`define OFS_STATUS     4'h5
`define OFS_VECTOR_LO  4'h6
`define OFS_VECTOR_HI  4'h7

// Reset values
`define SENSE_RESET    8'h00
`define ENABLE_RESET   14'h0000

// Sensitivity codes per external line
`define SENS_FALL_LOW  2'h0
`define SENS_RISE      2'h1
`define SENS_FALL      2'h2
`define SENS_BOTH      2'h3

// Vector addresses
`define VEC_TRAP       16'hFFFC
`define VEC_SRC0       16'hFFFA

// Source numbers with special wake or request roles
`define SRC_AWU        4'h0
`define SRC_EXT0       4'h1
`define SRC_AVD        4'h7
`define SRC_AT_OVF     4'h9
`define SRC_RTC1       4'hB
`define SRC_SPI        4'hC

// Halt exit masks, bit n for source n
`define HALT_WAKE_MASK   14'h101E
`define ACTIVE_WAKE_MASK 14'h0A00
`define AWU_WAKE_MASK    14'h0001

`endif

/* File: verilog/vectored_interrupt_controller.v */
// Vectored fixed-priority interrupt controller for an 8-bit core
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defines.vh"

// Function
// - Maskable service only while global mask clear
// - Masked requests stay pending until unmasked
// - Reset disables peripheral and supply sources (lines stay enabled), mask set
// - Entry only at instruction boundary
// - Entry pushes PC, X, A, condition codes
// - Entry sets global mask bit
// - Load PC from serviced source vector
// - Return restores registers, clears mask, resumes
// - Fixed priority, lower number wins
// - Fourteen sources, descending two-byte vectors
// - Trap ignores mask, top rank, no halt wake
// - Any source wakes core from wait; here only enabled pending or low-level requests do
// - Only listed sources end halt
// - Special sources end only their halt kind
// - External vector only on event, mask clear
// - Edge latch clears on routine entry
// - Low NAND input blocks its source
// - Peripheral request needs enable and clear mask
// - Clearing sequence drops internal latch
// - Supply detect flag requests, clears on entry
// - Two-bit sensitivity code per external line
// - Sensitivity writes only while mask set
module vectored_interrupt_controller #(
  parameter NSRC = 14 // Number of maskable sources
) (
  // Clock, enable, reset
  input  wire        clock,
  input  wire        clk_en,
  input  wire        rst_n,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // External lines, already pin-selected
  input  wire        external_line_zero,
  input  wire        external_line_one,
  input  wire        external_line_two,
  input  wire        external_line_three,
  input  wire [3:0]  nand_block_n,
  // Peripheral events and their clearing sequences
  input  wire [NSRC-1:0] periph_flag,
  input  wire [NSRC-1:0] periph_clear,
  input  wire        supply_detect_flag,
  // Core handshake
  input  wire        instr_boundary,
  input  wire        trap_exec,
  input  wire        return_from_interrupt,
  input  wire        save_done,
  input  wire        restore_done,
  input  wire        wait_mode,
  input  wire        halt_mode,
  input  wire        active_halt_mode,
  input  wire        awu_halt_mode,
  // Core control outputs
  output reg         irq_take,
  output reg         push_context,
  output reg         pop_context,
  output reg         load_pc,
  output reg  [15:0] vector_addr,
  output reg         global_mask,
  output reg         wake_core
);

  // State codes of the entry/exit sequencer
  // RUN waits for a boundary, SAVE until the core has stacked the context,
  // LOAD lasts one cycle, RET until the core has unstacked it
  localparam ST_RUN  = 2'h0;
  localparam ST_SAVE = 2'h1;
  localparam ST_LOAD = 2'h2;
  localparam ST_RET  = 2'h3;

  // Reset synchroniser, rst_sync_reg feeds only rst_q_reg
  // Release is synchronous so no flop sees reset end inside its setup window
  reg rst_sync_reg;
  reg rst_q_reg;
  wire rst_int_n = rst_q_reg;

  // Software state
  reg [7:0]      sense_reg;     // Two bits per external line
  reg [NSRC-1:0] enable_reg;    // Per-source enables
  reg            supply_detect_irq_enable;
  // Pending latches
  reg [NSRC-1:0] pend_reg;      // Sticky pending bits
  reg [NSRC-1:0] pend_next;
  reg [3:0]      ext_prev_reg;  // Previous external levels
  // Sequencer
  reg [1:0]      state_reg;
  reg [1:0]      state_next;
  reg [3:0]      src_reg;       // Source under entry
  reg            trap_reg;      // Entry is for the trap

  // Vector of maskable source n, two bytes per step
  // Trap and reset vectors sit above the source 0 vector
  function [15:0] src_vector;
    input [3:0] n;
    begin
      src_vector = `VEC_SRC0 - {11'h000, n, 1'b0};
    end
  endfunction

  // Lowest pending-and-enabled source number
  // Walks downward so the lowest set bit is left last; 16 means none
  function [4:0] pick;
    input [NSRC-1:0] req;
    integer i;
    begin
      pick = 5'h10;
      for (i = NSRC - 1; i >= 0; i = i - 1) begin
        if (req[i]) begin
          pick = i[4:0];
        end
      end
    end
  endfunction

  // Edge and level detection per external line
  // Previous levels reset high, so an idle-high line gives no false edge
  // Line 0 is the low bit of the packed level
  wire [3:0] ext_now = {external_line_three, external_line_two,
                        external_line_one, external_line_zero};
  reg  [3:0] ext_event;
  reg  [3:0] ext_level;
  integer k;
  always @* begin
    ext_event = 4'h0;
    ext_level = 4'h0;
    for (k = 0; k < 4; k = k + 1) begin
      case (sense_reg[2*k +: 2])
        `SENS_FALL_LOW: begin
          ext_event[k] = ext_prev_reg[k] & ~ext_now[k];
          ext_level[k] = ~ext_now[k];
        end
        `SENS_RISE: ext_event[k] = ~ext_prev_reg[k] & ext_now[k];
        `SENS_FALL: ext_event[k] = ext_prev_reg[k] & ~ext_now[k];
        default:    ext_event[k] = ext_prev_reg[k] ^ ext_now[k];
      endcase
      // A low NAND input holds the source off, even for rising edges
      if (!nand_block_n[k]) begin
        ext_event[k] = 1'b0;
        ext_level[k] = 1'b0;
      end
    end
  end

  // Requests from every source before pending latch
  // Line and supply positions ignore the peripheral flag inputs
  reg [NSRC-1:0] raw_event;
  always @* begin
    raw_event = periph_flag;
    raw_event[`SRC_EXT0 +: 4] = ext_event;
    raw_event[`SRC_AVD] = supply_detect_flag;
  end

  // Effective enables: lines always enabled, supply detect own bit
  // Trade-off: lines carry no enable, pin selection gates them upstream
  reg [NSRC-1:0] eff_enable;
  always @* begin
    eff_enable = enable_reg;
    eff_enable[`SRC_EXT0 +: 4] = 4'hF;
    eff_enable[`SRC_AVD] = supply_detect_irq_enable;
  end

  // Low level request is not latched, it stands while the pin is low
  // Level requests sit at the source 1 to 4 positions
  wire [NSRC-1:0] level_req = {{(NSRC-5){1'b0}}, ext_level, 1'b0};
  wire [NSRC-1:0] active    = (pend_reg | level_req) & eff_enable;
  wire [4:0]      winner    = pick(active);
  wire            have_req  = ~winner[4];

  // Entry request at a boundary
  // A boundary is the only point where the core can give up the bus
  wire take_trap = trap_exec & instr_boundary;
  wire take_mask = have_req & ~global_mask & instr_boundary;

  // Pending latch update; set wins over clear
  // Clearing sequence first, then entry clear, then new events on top,
  // so an event in the clearing cycle is never lost
  always @* begin
    pend_next = pend_reg;
    pend_next = pend_next & ~periph_clear;
    // Entering a routine drops the latch of that source
    if (state_reg == ST_SAVE && !trap_reg) begin
      pend_next[src_reg] = 1'b0;
    end
    pend_next = pend_next | raw_event;
  end

  // Sequencer next state
  // Entry beats return when both come at one boundary
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (take_trap || take_mask) begin
          state_next = ST_SAVE;
        end else if (return_from_interrupt) begin
          state_next = ST_RET;
        end
      end
      ST_SAVE: begin
        if (save_done) begin
          state_next = ST_LOAD;
        end
      end
      ST_LOAD: state_next = ST_RUN;
      ST_RET: begin
        if (restore_done) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  // Wake decision per low power mode
  // Bit n of each mask stands for source n
  // Limitation: the special halt kinds only qualify halt_mode and
  // wake nothing while halt_mode is low
  wire [NSRC-1:0] halt_ok  = `HALT_WAKE_MASK
                           | (active_halt_mode ? `ACTIVE_WAKE_MASK : 14'h0000)
                           | (awu_halt_mode ? `AWU_WAKE_MASK : 14'h0000);
  wire wake_wait = |active;
  wire wake_halt = |(active & halt_ok);

  // Reset release through two flops
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 1'b0;
      rst_q_reg    <= 1'b0;
    end else begin
      rst_sync_reg <= 1'b1;
      rst_q_reg    <= rst_sync_reg;
    end
  end

  // Main state, frozen while the clock enable is low
  always @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      sense_reg                <= `SENSE_RESET;
      enable_reg               <= `ENABLE_RESET;
      supply_detect_irq_enable <= 1'b0;
      global_mask              <= 1'b1;
      pend_reg                 <= {NSRC{1'b0}};
      ext_prev_reg             <= 4'hF;
      state_reg                <= ST_RUN;
      src_reg                  <= 4'h0;
      trap_reg                 <= 1'b0;
      irq_take                 <= 1'b0;
      push_context             <= 1'b0;
      pop_context              <= 1'b0;
      load_pc                  <= 1'b0;
      // Vector starts on the trap entry so it never points outside the table
      vector_addr              <= `VEC_TRAP;
      wake_core                <= 1'b0;
      reg_rdata                <= 8'h00;
    end else if (clk_en) begin
      ext_prev_reg <= ext_now;
      pend_reg     <= pend_next;
      state_reg    <= state_next;
      // Pulse outputs fall unless set again below
      irq_take     <= 1'b0;
      load_pc      <= 1'b0;
      // Trap outranks every maskable source
      if (state_reg == ST_RUN && take_trap) begin
        trap_reg <= 1'b1;
        irq_take <= 1'b1;
      end else if (state_reg == ST_RUN && take_mask) begin
        trap_reg <= 1'b0;
        src_reg  <= winner[3:0];
        irq_take <= 1'b1;
      end
      // Context pushed during save, mask set by hardware
      push_context <= (state_next == ST_SAVE);
      if (state_reg == ST_SAVE) begin
        global_mask <= 1'b1;
      end
      // Vector load once the stack holds the context
      if (state_reg == ST_SAVE && save_done) begin
        load_pc     <= 1'b1;
        vector_addr <= trap_reg ? `VEC_TRAP : src_vector(src_reg);
      end
      // Return pops, then clears the mask
      pop_context <= (state_next == ST_RET);
      if (state_reg == ST_RET && restore_done) begin
        global_mask <= 1'b0;
      end
      // Trap never ends halt; wait counts every enabled source
      wake_core <= (wait_mode & wake_wait) | (halt_mode & wake_halt);
      // Register writes
      if (reg_wr) begin
        case (reg_addr)
          `OFS_SENSE: begin
            // Codes are locked while requests can be taken
            if (global_mask) begin
              sense_reg <= reg_wdata;
            end
          end
          `OFS_ENABLE_LO: enable_reg[7:0] <= reg_wdata;
          `OFS_ENABLE_HI: begin
            enable_reg[NSRC-1:8] <= reg_wdata[NSRC-9:0];
            supply_detect_irq_enable <= reg_wdata[7];
          end
          `OFS_STATUS: begin
            // Hardware set on entry outranks a software clear in one cycle
            if (state_reg != ST_SAVE) begin
              global_mask <= reg_wdata[0];
            end
          end
          // Unmapped and read-only offsets ignore writes
          default: ;
        endcase
      end
      // Read data in the following cycle, zero when unmapped
      // Zero between reads keeps the port quiet for an OR-combined read bus
      // Pending reads show latches only; level requests are not visible
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `OFS_SENSE:     reg_rdata <= sense_reg;
          `OFS_ENABLE_LO: reg_rdata <= enable_reg[7:0];
          `OFS_ENABLE_HI: reg_rdata <= {supply_detect_irq_enable, 1'b0,
                                        enable_reg[NSRC-1:8]};
          `OFS_PEND_LO:   reg_rdata <= pend_reg[7:0];
          `OFS_PEND_HI:   reg_rdata <= {2'h0, pend_reg[NSRC-1:8]};
          `OFS_STATUS:    reg_rdata <= {3'h0, winner};
          `OFS_VECTOR_LO: reg_rdata <= vector_addr[7:0];
          `OFS_VECTOR_HI: reg_rdata <= vector_addr[15:8];
          default:        reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule
`default_nettype wire
